// ===== verilog/dcm_top.sv
/*
 dcm_top: write leveling feedback and exit, and calibration pattern readout,
 of the device side, with an axi4-lite register slave.
 assumes: link pins are sampled by aclk (10 mhz) through two flops; the
 link clock is much slower than aclk; the controller keeps its own timings.
*/
`timescale 1ns/100ps
`include "dcm_params.svh"
module dcm_top
	import dcm_pkg::*;
#(
	parameter int ADDR_W = 4,
	parameter int TMOD_CK = `DCM_TMOD_CK
) (
	input logic aclk,
	input logic aresetn,
	input logic [ADDR_W-1:0] awaddr,
	input logic awvalid,
	output logic awready,
	input logic [31:0] wdata,
	input logic [3:0] wstrb,
	input logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input logic bready,
	input logic [ADDR_W-1:0] araddr,
	input logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input logic rready,
	input logic ck,
	input logic cs_n,
	input logic ras_n,
	input logic cas_n,
	input logic we_n,
	input logic [2:0] ba,
	input logic [14:0] addr,
	input logic odt,
	input logic dqs_in,
	output logic [7:0] dq_out,
	output logic dq_oe_n,
	output logic dqs_out,
	output logic dqs_oe_n,
	output logic term_dqs_on,
	output logic term_dq_on,
	output logic array_access
);
	if (ADDR_W < 4) begin : g_bad_addr
		$error("dcm_top needs at least four address bits");
	end
	if (TMOD_CK < 1 || TMOD_CK > 255) begin : g_bad_tmod
		$error("dcm_top tmod count must be 1 to 255");
	end
	localparam int SW = 25;
	localparam int P_CK = 24;
	localparam int P_DQS = 23;
	localparam int P_ODT = 22;
	////////////////////////////////////////////////////////////////////////
	// pin sampling
	logic [SW-1:0] pin_q;
	logic [SW-1:0] pin_rise;
	logic [SW-1:0] pin_fall;
	// every pin passes two flops before use
	dcm_sync #(
		.W(SW)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({ck, dqs_in, odt, cs_n, ras_n, cas_n, we_n, ba, addr}),
		.q(pin_q),
		.rise(pin_rise),
		.fall(pin_fall)
	);
	logic ck_s;
	logic odt_s;
	logic [2:0] ba_s;
	logic [14:0] addr_s;
	dcm_cmd_e cmd;
	logic cmd_valid;
	logic mrs_cmd;
	logic rd_cmd;
	logic wr_cmd;
	logic nop_cmd;
	logic dqs_rise;
	// command decode at each sampled link clock rise
	assign ck_s = pin_q[P_CK];
	assign odt_s = pin_q[P_ODT];
	assign dqs_rise = pin_rise[P_DQS];
	assign ba_s = pin_q[17:15];
	assign addr_s = pin_q[14:0];
	assign cmd = dcm_cmd_e'(pin_q[20:18]);
	assign cmd_valid = pin_rise[P_CK] && !pin_q[21];
	assign mrs_cmd = cmd_valid && cmd == DCM_CMD_MRS;
	assign rd_cmd = cmd_valid && cmd == DCM_CMD_RD;
	assign wr_cmd = cmd_valid && cmd == DCM_CMD_WR;
	assign nop_cmd = !cmd_valid || cmd == DCM_CMD_NOP;
	////////////////////////////////////////////////////////////////////////
	// mode state set by mode register commands
	logic wl_reg;
	logic cal_reg;
	logic [1:0] loc_reg;
	logic [1:0] bl_reg;
	logic [7:0] mod_cnt_reg;
	logic undef;
	// write leveling, calibration enable, location and burst mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wl_reg <= 1'b0;
			cal_reg <= 1'b0;
			loc_reg <= 2'h0;
			bl_reg <= 2'h0;
		end else if (mrs_cmd) begin
			if (ba_s == 3'h1) begin
				wl_reg <= addr_s[`DCM_MR1_WL_BIT];
			end else if (ba_s == 3'h3) begin
				cal_reg <= addr_s[`DCM_MR3_CAL_BIT];
				loc_reg <= addr_s[1:0];
			end else if (ba_s == 3'h0) begin
				bl_reg <= addr_s[1:0];
			end
		end
	end
	// dq stays undefined from leveling exit until tmod link clocks pass
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mod_cnt_reg <= 8'h00;
		end else if (mrs_cmd && ba_s == 3'h1 && wl_reg && !addr_s[`DCM_MR1_WL_BIT]) begin
			mod_cnt_reg <= 8'(TMOD_CK);
		end else if (pin_rise[P_CK] && mod_cnt_reg != 8'h00) begin
			mod_cnt_reg <= mod_cnt_reg - 8'h01;
		end
	end
	assign undef = (mod_cnt_reg != 8'h00);
	////////////////////////////////////////////////////////////////////////
	// registers written by software
	logic [1:0] ctrl_reg;
	logic [5:0] lat_reg;
	logic err_reg;
	logic err_clr;
	logic illegal;
	// commands other than reads, mode commands and nops during calibration, or
	// other than mode commands and nops during leveling, are recorded
	assign illegal = cmd_valid &&
		((cal_reg && !rd_cmd && !mrs_cmd && !nop_cmd) ||
		(wl_reg && !mrs_cmd && !nop_cmd));
	////////////////////////////////////////////////////////////////////////
	// calibration read launch
	dcm_rd_if rdi ();
	dcm_read_path u_read (
		.aclk(aclk),
		.aresetn(aresetn),
		.rd(rdi)
	);
	assign rdi.start = rd_cmd && cal_reg;
	// on-the-fly chop from address bit 12 low, else fixed by mode zero
	assign rdi.bc4 = (bl_reg == `DCM_BL_OTF) ? !addr_s[`DCM_BC_SEL_BIT] :
		(bl_reg == `DCM_BL_BC4);
	// a2 picks the nibble only for burst chop; eight beats start at zero
	assign rdi.upper = addr_s[2] && rdi.bc4;
	assign rdi.rl = lat_reg;
	// reserved locations read as zero
	assign rdi.pattern = (loc_reg == `DCM_LOC_PATTERN) ? `DCM_PATTERN : 8'h00;
	assign rdi.ck_rise = pin_rise[P_CK];
	assign rdi.ck_fall = pin_fall[P_CK];
	////////////////////////////////////////////////////////////////////////
	// leveling feedback: link clock level sampled at each strobe rise
	logic fb_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fb_reg <= 1'b0;
		end else if (wl_reg && dqs_rise) begin
			fb_reg <= ck_s;
		end else if (!wl_reg && !undef) begin
			fb_reg <= 1'b0;
		end
	end
	// dq and strobe drivers, reads take precedence over leveling
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dq_out <= 8'h00;
			dq_oe_n <= 1'b1;
			dqs_out <= 1'b0;
			dqs_oe_n <= 1'b1;
		end else if (rdi.drive) begin
			dq_out <= ctrl_reg[`DCM_CTRL_REP_BIT] ? {8{rdi.beat}} : {7'h00, rdi.beat};
			dq_oe_n <= 1'b0;
			dqs_out <= rdi.strobe;
			dqs_oe_n <= 1'b0;
		end else if (wl_reg || undef) begin
			dq_out <= ctrl_reg[`DCM_CTRL_ALLFB_BIT] ? {8{fb_reg}} : {7'h00, fb_reg};
			dq_oe_n <= 1'b0;
			dqs_out <= 1'b0;
			dqs_oe_n <= 1'b1;
		end else begin
			dq_out <= 8'h00;
			dq_oe_n <= 1'b1;
			dqs_out <= 1'b0;
			dqs_oe_n <= 1'b1;
		end
	end
	// termination: leveling keeps dq termination off whatever odt does
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			term_dqs_on <= 1'b0;
			term_dq_on <= 1'b0;
		end else begin
			term_dqs_on <= odt_s;
			term_dq_on <= odt_s && !wl_reg;
		end
	end
	// normal mode hands reads and writes to the array
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			array_access <= 1'b0;
		end else begin
			array_access <= (rd_cmd || wr_cmd) && !cal_reg;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// axi4-lite write channel, address and data taken in either order
	logic aw_got_reg;
	logic w_got_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_fire;
	logic wr_hit;
	assign awready = !aw_got_reg && !bvalid;
	assign wready = !w_got_reg && !bvalid;
	assign wr_fire = aw_got_reg && w_got_reg;
	assign wr_hit = awaddr_reg == ADDR_W'(`DCM_OFS_CTRL) ||
		awaddr_reg == ADDR_W'(`DCM_OFS_LAT) || awaddr_reg == ADDR_W'(`DCM_OFS_STAT);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= awaddr;
			end else if (wr_fire) begin
				aw_got_reg <= 1'b0;
			end
			if (wvalid && wready) begin
				w_got_reg <= 1'b1;
				wdata_reg <= wdata;
				wstrb_reg <= wstrb;
			end else if (wr_fire) begin
				w_got_reg <= 1'b0;
			end
		end
	end
	// write response one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `DCM_RESP_OK;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= wr_hit ? `DCM_RESP_OK : `DCM_RESP_ERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end
	assign err_clr = wr_fire && awaddr_reg == ADDR_W'(`DCM_OFS_STAT) &&
		wstrb_reg[1] && wdata_reg[`DCM_ST_ERR];
	// control and latency registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= `DCM_CTRL_RST;
			lat_reg <= `DCM_LAT_RST;
		end else if (wr_fire && wstrb_reg[0]) begin
			if (awaddr_reg == ADDR_W'(`DCM_OFS_CTRL)) begin
				ctrl_reg <= wdata_reg[1:0];
			end else if (awaddr_reg == ADDR_W'(`DCM_OFS_LAT)) begin
				lat_reg <= wdata_reg[5:0];
			end
		end
	end
	// sticky command error, a new event wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_reg <= 1'b0;
		end else if (illegal) begin
			err_reg <= 1'b1;
		end else if (err_clr) begin
			err_reg <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// axi4-lite read channel
	logic [31:0] stat_word;
	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[`DCM_ST_WL] = wl_reg;
		stat_word[`DCM_ST_CAL] = cal_reg;
		stat_word[`DCM_ST_LOC +: 2] = loc_reg;
		stat_word[`DCM_ST_OTF] = (bl_reg == `DCM_BL_OTF);
		stat_word[`DCM_ST_TDQS] = term_dqs_on;
		stat_word[`DCM_ST_TDQ] = term_dq_on;
		stat_word[`DCM_ST_BUSY] = rdi.busy;
		stat_word[`DCM_ST_ERR] = err_reg;
		stat_word[`DCM_ST_UNDEF] = undef;
	end
	assign arready = !rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `DCM_RESP_OK;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= `DCM_RESP_OK;
			if (araddr == ADDR_W'(`DCM_OFS_CTRL)) begin
				rdata <= {30'h0000_0000, ctrl_reg};
			end else if (araddr == ADDR_W'(`DCM_OFS_LAT)) begin
				rdata <= {26'h000_0000, lat_reg};
			end else if (araddr == ADDR_W'(`DCM_OFS_STAT)) begin
				rdata <= stat_word;
			end else begin
				rdata <= 32'h0000_0000;
				rresp <= `DCM_RESP_ERR;
			end
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_wl_enter: assert property (mrs_cmd && ba_s == 3'h1 |=>
		wl_reg == $past(addr_s[`DCM_MR1_WL_BIT]))
		else $error("leveling mode not set by mode register one");
	chk_wl_term: assert property ($past(wl_reg) |-> !term_dq_on &&
		term_dqs_on == $past(odt_s))
		else $error("dq termination on during leveling");
	chk_prime_low: assert property (dq_out[7:1] != 7'h00 |->
		$past(rdi.drive) || ($past(wl_reg || undef) && $past(ctrl_reg[1])))
		else $error("non-prime dq not low");
	chk_exit_undef: assert property ($fell(wl_reg) |=> !dq_oe_n [*8])
		else $error("dq released before tmod after exit");
	chk_cal_enable: assert property (mrs_cmd && ba_s == 3'h3 |=>
		cal_reg == $past(addr_s[2]))
		else $error("calibration mode not set by bit 2");
	chk_cal_read: assert property (rd_cmd && cal_reg && !rdi.busy |=>
		rdi.busy && !array_access)
		else $error("calibration read not served");
	chk_array_normal: assert property ((rd_cmd || wr_cmd) && !cal_reg |=> array_access)
		else $error("normal access not sent to array");
	chk_dq_copy: assert property (rdi.drive && ctrl_reg[0] |=>
		dq_out == {8{$past(rdi.beat)}})
		else $error("dq7..1 do not follow dq0");
	cov_wl_feedback: cover property (wl_reg && fb_reg && !dq_oe_n);
	cov_cal_exit: cover property ($fell(cal_reg));
endmodule : dcm_top

// ===== inc/dcm_params.svh
/*
 constants of the calibration-mode block: register offsets, field positions,
 reset values, mode register bit positions and cycle counts.
 assumes: included by its bare name from dcm_top and the testbench.
*/
`ifndef DCM_PARAMS_SVH
`define DCM_PARAMS_SVH
// register byte offsets on the register bus
`define DCM_OFS_CTRL 4'h0
`define DCM_OFS_LAT 4'h4
`define DCM_OFS_STAT 4'h8
// control register fields and reset
`define DCM_CTRL_REP_BIT 0
`define DCM_CTRL_ALLFB_BIT 1
`define DCM_CTRL_RST 2'h1
// read latency register, in link clock cycles
`define DCM_LAT_RST 6'h06
// status register fields
`define DCM_ST_WL 0
`define DCM_ST_CAL 1
`define DCM_ST_LOC 2
`define DCM_ST_OTF 4
`define DCM_ST_TDQS 5
`define DCM_ST_TDQ 6
`define DCM_ST_BUSY 7
`define DCM_ST_ERR 8
`define DCM_ST_UNDEF 9
// mode register and read command bit positions on the address pins
`define DCM_MR1_WL_BIT 7
`define DCM_MR3_CAL_BIT 2
`define DCM_BC_SEL_BIT 12
// mode register three location select and mode register zero burst field
`define DCM_LOC_PATTERN 2'h0
`define DCM_BL_OTF 2'h1
`define DCM_BL_BC4 2'h2
// training pattern, burst order bit 0 in the lsb
`define DCM_PATTERN 8'haa
// settle time after a mode register command, in link clock cycles
`define DCM_TMOD_CK 8'h0c
// bus responses
`define DCM_RESP_OK 2'h0
`define DCM_RESP_ERR 2'h2
`endif

// ===== inc/dcm_pkg.sv
/*
 types of the calibration-mode block: command codes and read path states.
 assumes: nothing beyond the params header.
*/
package dcm_pkg;
	// {ras_n, cas_n, we_n} while cs_n is low
	typedef enum logic [2:0] {
		DCM_CMD_MRS = 3'h0,
		DCM_CMD_REF = 3'h1,
		DCM_CMD_PRE = 3'h2,
		DCM_CMD_ACT = 3'h3,
		DCM_CMD_WR = 3'h4,
		DCM_CMD_RD = 3'h5,
		DCM_CMD_ZQ = 3'h6,
		DCM_CMD_NOP = 3'h7
	} dcm_cmd_e;
	// gray coded along idle, latency, burst
	typedef enum logic [1:0] {
		DCM_RD_IDLE = 2'h0,
		DCM_RD_LAT = 2'h1,
		DCM_RD_BURST = 2'h3
	} dcm_rd_state_e;
	typedef logic [7:0] dcm_byte_t;
endpackage : dcm_pkg

// ===== inc/dcm_rd_if.sv
/*
 dcm_rd_if: carries a calibration read from the command decoder to the
 read path and the beats back.
 assumes: both ends run on aclk.
*/
`timescale 1ns/100ps
interface dcm_rd_if;
	import dcm_pkg::*;
	logic start;
	logic bc4;
	logic upper;
	logic [5:0] rl;
	dcm_byte_t pattern;
	logic ck_rise;
	logic ck_fall;
	logic busy;
	logic beat;
	logic strobe;
	logic drive;
	modport ctl (output start, bc4, upper, rl, pattern, ck_rise, ck_fall,
		input busy, beat, strobe, drive);
	modport srv (input start, bc4, upper, rl, pattern, ck_rise, ck_fall,
		output busy, beat, strobe, drive);
endinterface : dcm_rd_if

// ===== verilog/dcm_sync.sv
/*
 dcm_sync: two-flop synchroniser per bit with rise and fall detection.
 assumes: inputs come from pins outside the aclk domain.
*/
`timescale 1ns/100ps
module dcm_sync #(
	parameter int W = 1
) (
	input logic aclk,
	input logic aresetn,
	input logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	if (W < 1) begin : g_bad_w
		$error("dcm_sync needs at least one bit");
	end
	////////////////////////////////////////////////////////////////////////
	// per bit: first flop feeds only the second, third flop keeps history
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic s1_reg;
		logic s2_reg;
		logic s3_reg;
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				s1_reg <= 1'b0;
				s2_reg <= 1'b0;
				s3_reg <= 1'b0;
			end else begin
				s1_reg <= d[i];
				s2_reg <= s1_reg;
				s3_reg <= s2_reg;
			end
		end
		assign q[i] = s2_reg;
		assign rise[i] = s2_reg & ~s3_reg;
		assign fall[i] = ~s2_reg & s3_reg;
	end
endmodule : dcm_sync

// ===== verilog/dcm_read_path.sv
/*
 dcm_read_path: counts read latency, then sends one pattern bit per link
 clock edge in the selected burst order.
 assumes: start comes on a link clock rise; a start while busy is ignored.
*/
`timescale 1ns/100ps
module dcm_read_path
	import dcm_pkg::*;
(
	input logic aclk,
	input logic aresetn,
	dcm_rd_if.srv rd
);
	dcm_rd_state_e state_reg;
	logic [5:0] cnt_reg;
	logic [2:0] idx_reg;
	logic [2:0] left_reg;
	dcm_byte_t pat_reg;
	logic beat_reg;
	logic strobe_reg;
	logic drive_reg;
	logic bc4_reg;
	logic upper_reg;
	logic [5:0] rl_reg;
	////////////////////////////////////////////////////////////////////////
	// latency count then one beat per rise and fall
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= DCM_RD_IDLE;
			cnt_reg <= 6'h00;
			idx_reg <= 3'h0;
			left_reg <= 3'h0;
			pat_reg <= 8'h00;
			beat_reg <= 1'b0;
			strobe_reg <= 1'b0;
			drive_reg <= 1'b0;
			bc4_reg <= 1'b0;
			upper_reg <= 1'b0;
			rl_reg <= 6'h00;
		end else begin
			case (state_reg)
				DCM_RD_IDLE: begin
					if (rd.start) begin
						state_reg <= DCM_RD_LAT;
						cnt_reg <= rd.rl;
						rl_reg <= rd.rl;
						pat_reg <= rd.pattern;
						bc4_reg <= rd.bc4;
						upper_reg <= rd.upper;
						idx_reg <= rd.upper ? 3'h4 : 3'h0;
						left_reg <= rd.bc4 ? 3'h3 : 3'h7;
					end
				end
				DCM_RD_LAT: begin
					if (rd.ck_rise) begin
						if (cnt_reg <= 6'h01) begin
							state_reg <= DCM_RD_BURST;
							drive_reg <= 1'b1;
							beat_reg <= pat_reg[idx_reg];
							strobe_reg <= 1'b1;
						end else begin
							cnt_reg <= cnt_reg - 6'h01;
						end
					end
				end
				DCM_RD_BURST: begin
					if (rd.ck_rise || rd.ck_fall) begin
						if (left_reg == 3'h0) begin
							state_reg <= DCM_RD_IDLE;
							drive_reg <= 1'b0;
							strobe_reg <= 1'b0;
						end else begin
							idx_reg <= idx_reg + 3'h1;
							left_reg <= left_reg - 3'h1;
							beat_reg <= pat_reg[idx_reg + 3'h1];
							strobe_reg <= rd.ck_rise;
						end
					end
				end
				default: begin
					state_reg <= DCM_RD_IDLE;
				end
			endcase
		end
	end
	assign rd.busy = (state_reg != DCM_RD_IDLE);
	assign rd.beat = beat_reg;
	assign rd.strobe = strobe_reg;
	assign rd.drive = drive_reg;
	////////////////////////////////////////////////////////////////////////
	// checking helpers: rises seen during latency, beats sent
	logic [6:0] seen_reg;
	logic [3:0] sent_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seen_reg <= 7'h00;
			sent_reg <= 4'h0;
		end else begin
			if (state_reg == DCM_RD_IDLE) begin
				seen_reg <= 7'h00;
			end else if (state_reg == DCM_RD_LAT && rd.ck_rise) begin
				seen_reg <= seen_reg + 7'h01;
			end
			if (state_reg == DCM_RD_IDLE) begin
				sent_reg <= 4'h0;
			end else if (state_reg == DCM_RD_BURST && (rd.ck_rise || rd.ck_fall)) begin
				sent_reg <= sent_reg + 4'h1;
			end
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_read_latency: assert property ($rose(drive_reg) |->
		seen_reg == ((rl_reg == 6'h00) ? 7'h01 : {1'b0, rl_reg}))
		else $error("burst began at wrong latency");
	chk_burst_length: assert property ($fell(drive_reg) |->
		$past(sent_reg) == (bc4_reg ? 4'h3 : 4'h7))
		else $error("wrong number of beats");
	chk_nibble_start: assert property ($rose(drive_reg) |->
		idx_reg == (upper_reg ? 3'h4 : 3'h0))
		else $error("burst began at wrong nibble");
	chk_beat_order: assert property (drive_reg && !$rose(drive_reg) |->
		beat_reg == pat_reg[idx_reg])
		else $error("beat does not follow burst order");
	cov_bl8: cover property ($fell(drive_reg) && !bc4_reg);
	cov_bc4_upper: cover property ($rose(drive_reg) && bc4_reg && upper_reg);
endmodule : dcm_read_path

// ===== bench/dcm_ctl_model.sv
/*
 dcm_ctl_model: the memory controller side of the link, with a free
 running command clock, commands, odt and the leveling strobe.
 assumes: the device samples its pins near each ck rise.
*/
`timescale 1ns/100ps
module dcm_ctl_model
	import dcm_pkg::*;
(
	output logic ck,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [2:0] ba,
	output logic [14:0] addr,
	output logic odt,
	output logic dqs_in
);
	// idle pins, then an 800 ns clock that runs free
	initial begin
		{cs_n, ras_n, cas_n, we_n, odt, dqs_in} = 6'h3c;
		ba = 3'h0;
		addr = 15'h0000;
		ck = 1'b0;
		forever #400 ck = ~ck;
	end
	////////////////////////////////////////////////////////////////
	// command launched on the fall before its rise; gap in ck cycles after
	task automatic cmd(input dcm_cmd_e c, input logic [2:0] b, input logic [14:0] a,
		input int gap);
		@(negedge ck);
		{cs_n, ras_n, cas_n, we_n} = {1'b0, c};
		ba = b;
		addr = a;
		@(negedge ck);
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
		ba = ~b; // released lines keep no stale value
		addr = ~a;
		repeat (gap) @(negedge ck);
	endtask : cmd
	// odt changes a half ck before the sampling rise
	task automatic set_odt(input logic v);
		@(negedge ck);
		odt = v;
	endtask : set_odt
	// one strobe pulse in the ck high phase, strobe parked low after it
	task automatic strobe;
		@(posedge ck);
		#200 dqs_in = 1'b1;
		#200 dqs_in = 1'b0;
	endtask : strobe
endmodule : dcm_ctl_model

// ===== bench/testbench.sv
/*
 testbench: drives dcm_top over axi4-lite and through the controller model.
 assumes: dcm_top built with a short settle count TMOD_CK of 2.
*/
`timescale 1ns/100ps
`include "dcm_params.svh"
module testbench
	import dcm_pkg::*;
;
	localparam int TMOD = 2;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, ck, cs_n, ras_n, cas_n, we_n, odt, dqs_in;
	logic dq_oe_n, dqs_out, dqs_oe_n, term_dqs_on, term_dq_on, array_access;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, rd_word;
	logic [1:0] bresp, rresp, rd_resp;
	logic [2:0] ba;
	logic [14:0] addr;
	logic [7:0] dq_out;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	dcm_top #(.TMOD_CK(TMOD)) dcm_top_i (.*);
	dcm_ctl_model dcm_ctl_model_i (.*);
	// clock and hang limit
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s: %h not %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	// one write; address and data offered together, released as taken
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		rd_resp = bresp;
	endtask : axi_wr
	task automatic axi_rd(input logic [3:0] a);
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'h3};
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		{rd_word, rd_resp} = {rdata, rresp};
	endtask : axi_rd
	// one calibration read: latency, beats, strobe, release
	task automatic cal_rd(input logic [14:0] a, input int n, input int first,
		input logic [7:0] pat, input logic rep, input int lat);
		int k;
		logic b;
		dcm_ctl_model_i.cmd(DCM_CMD_RD, 3'h5, a, 0);
		repeat ((lat - 1) * 8) @(negedge aclk);
		chk(dq_oe_n, 1'b1, "early beat");
		for (k = 0; k < 12 && dq_oe_n !== 1'b0; k++) @(negedge aclk);
		chk(dq_oe_n, 1'b0, "late beat");
		for (k = 0; k < n; k++) begin
			b = pat[first + k];
			chk(dq_out, rep ? {8{b}} : {7'h00, b}, "beat");
			chk(dqs_out, (k[0] == 1'b0), "strobe");
			chk(dqs_oe_n, 1'b0, "strobe driven");
			repeat (4) @(negedge aclk);
		end
		chk(dq_oe_n, 1'b1, "burst length");
	endtask : cal_rd
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		chk({dq_oe_n, dqs_oe_n}, 2'h3, "reset pins");
		axi_rd(`DCM_OFS_LAT);
		chk(rd_word, 32'h0000_0006, "latency reset");
		axi_rd(4'hc);
		chk(rd_word, 32'h0000_0000, "unmapped data");
		chk(rd_resp, 2'h2, "unmapped resp");
	endtask : t_regs
	task automatic t_level;
		dcm_ctl_model_i.cmd(DCM_CMD_MRS, 3'h1, 15'h0080, TMOD);
		dcm_ctl_model_i.set_odt(1'b1);
		repeat (2) @(negedge ck);
		chk({dq_oe_n, term_dqs_on, term_dq_on}, 3'h2, "leveling odt");
		dcm_ctl_model_i.strobe();
		repeat (4) @(negedge aclk);
		chk(dq_out, 8'h01, "feedback");
		axi_wr(`DCM_OFS_CTRL, 32'h0000_0003);
		chk(rd_resp, 2'h0, "write resp");
		@(negedge aclk);
		chk(dq_out, 8'hff, "all feedback");
		dcm_ctl_model_i.set_odt(1'b0);
		repeat (2) @(negedge ck);
		chk(term_dqs_on, 1'b0, "term off");
		dcm_ctl_model_i.cmd(DCM_CMD_MRS, 3'h1, 15'h0000, 0);
		chk(dq_oe_n, 1'b0, "exit window");
		repeat (TMOD + 2) @(negedge ck);
		chk(dq_oe_n, 1'b1, "exit released");
	endtask : t_level
	task automatic t_cal;
		dcm_ctl_model_i.cmd(DCM_CMD_PRE, 3'h0, 15'h0400, 2);
		dcm_ctl_model_i.cmd(DCM_CMD_MRS, 3'h3, 15'h0004, TMOD);
		axi_rd(`DCM_OFS_STAT);
		chk(rd_word[`DCM_ST_CAL], 1'b1, "cal flag");
		cal_rd(15'h1000, 8, 0, 8'haa, 1'b1, 6);
		axi_wr(`DCM_OFS_LAT, 32'h0000_0003);
		axi_wr(`DCM_OFS_CTRL, 32'h0000_0000);
		dcm_ctl_model_i.cmd(DCM_CMD_MRS, 3'h0, 15'h0002, TMOD);
		cal_rd(15'h0404, 4, 4, 8'haa, 1'b0, 3);
		dcm_ctl_model_i.cmd(DCM_CMD_MRS, 3'h0, 15'h0001, TMOD);
		cal_rd(15'h0000, 4, 0, 8'haa, 1'b0, 3);
		cal_rd(15'h1000, 8, 0, 8'haa, 1'b0, 3);
		dcm_ctl_model_i.cmd(DCM_CMD_MRS, 3'h3, 15'h0005, TMOD);
		cal_rd(15'h1000, 8, 0, 8'h00, 1'b0, 3);
		dcm_ctl_model_i.cmd(DCM_CMD_WR, 3'h0, 15'h0000, 2);
		axi_rd(`DCM_OFS_STAT);
		chk(rd_word[`DCM_ST_ERR], 1'b1, "write refused");
		axi_wr(`DCM_OFS_STAT, 32'h0000_0100);
		axi_rd(`DCM_OFS_STAT);
		chk(rd_word[`DCM_ST_ERR], 1'b0, "error cleared");
	endtask : t_cal
	task automatic t_normal;
		int k;
		dcm_ctl_model_i.cmd(DCM_CMD_MRS, 3'h3, 15'h0000, TMOD);
		k = 0;
		fork
			dcm_ctl_model_i.cmd(DCM_CMD_RD, 3'h0, 15'h0000, 0);
			repeat (40) begin
				@(negedge aclk);
				if (array_access === 1'b1) k++;
			end
		join
		chk(k, 1, "array read");
		chk(dq_oe_n, 1'b1, "no pattern");
	endtask : t_normal
	// reset, then the scenarios in turn
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = {8'h00, 32'h0000_0000, 4'hf};
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		t_regs();
		t_level();
		t_cal();
		t_normal();
		close_out();
	end
endmodule : testbench
